// ---- rtl/hsp_top.sv ----
// Host slave port: AHB-Lite registers and strobe-driven parallel port
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
module hsp_top
    import hsp_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] pd_in,
    output logic [7:0] pd_out,
    output logic [7:0] pd_oe,
    input wire logic [3:0] pe_in,
    output logic [2:0] pe_out,
    output logic [2:0] pe_oe,
    output logic slave_port_irq
);
    hsp_strb_s sync1_ff, sync2_ff, nxt_sync1_ff, nxt_sync2_ff;
    logic [7:0] pd1_ff, pd2_ff, nxt_pd1_ff, nxt_pd2_ff;
    logic [1:0] q_ff, nxt_q_ff;
    logic wr_act_ff, rd_act_ff, nxt_wr_act_ff, nxt_rd_act_ff;
    hsp_seq_e wseq_ff, rseq_ff, nxt_wseq_ff, nxt_rseq_ff;

    logic dph_ff, dwr_ff, rwait_ff, nxt_dph_ff, nxt_dwr_ff, nxt_rwait_ff;
    logic [7:0] didx_ff, nxt_didx_ff;
    logic [31:0] hrdata_ff, nxt_hrdata_ff;

    logic [7:0] in_lat_ff, out_lat_ff, ddir_ff, irqf_ff, irqe_ff, anlg_ff;
    logic [7:0] nxt_in_lat_ff, nxt_out_lat_ff, nxt_ddir_ff;
    logic [7:0] nxt_irqf_ff, nxt_irqe_ff, nxt_anlg_ff;
    logic [2:0] pe_lat_ff, dir_ff, nxt_pe_lat_ff, nxt_dir_ff;
    logic mode_ff, ibf_ff, obf_ff, input_overflow_flag_ff, ovf_rd_ff;
    logic nxt_mode_ff, nxt_ibf_ff, nxt_obf_ff, nxt_input_overflow_flag_ff, nxt_ovf_rd_ff;

    logic wr_act, rd_act, wr_end, rd_end, w_fire, r_fire;
    logic acc, wcmt, rcap, data_rd, data_wr;
    logic [7:0] rd_val;
    logic [7:0] wbyte;

    // Strobes only qualify in slave mode; pins taken through two flops
    always_comb begin
        nxt_sync1_ff = hsp_strb_s'({pe_in[2], pe_in[1], pe_in[0]});
        nxt_sync2_ff = sync1_ff;
        nxt_pd1_ff = pd_in;
        nxt_pd2_ff = pd1_ff;
        nxt_q_ff = q_ff + 2'h1;
        wr_act = mode_ff && !sync2_ff.cs_n && !sync2_ff.wr_n;
        rd_act = mode_ff && !sync2_ff.cs_n && !sync2_ff.rd_n;
        wr_end = wr_act_ff && !wr_act;
        rd_end = rd_act_ff && !rd_act;
        nxt_wr_act_ff = wr_act;
        nxt_rd_act_ff = rd_act;
        // A new end that lands while one is pending merges into it, except in its firing cycle, where it starts a new wait
        nxt_wseq_ff = seq_next(wseq_ff, wr_end, q_ff);
        nxt_rseq_ff = seq_next(rseq_ff, rd_end, q_ff);
        w_fire = seq_fire(wseq_ff, q_ff);
        r_fire = seq_fire(rseq_ff, q_ff);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
            pd1_ff <= LAT_RST;
            pd2_ff <= LAT_RST;
            q_ff <= 2'h0;
            wr_act_ff <= 1'b0;
            rd_act_ff <= 1'b0;
            wseq_ff <= ST_IDLE;
            rseq_ff <= ST_IDLE;
        end else if (ce) begin
            sync1_ff <= nxt_sync1_ff;
            sync2_ff <= nxt_sync2_ff;
            pd1_ff <= nxt_pd1_ff;
            pd2_ff <= nxt_pd2_ff;
            q_ff <= nxt_q_ff;
            wr_act_ff <= nxt_wr_act_ff;
            rd_act_ff <= nxt_rd_act_ff;
            wseq_ff <= nxt_wseq_ff;
            rseq_ff <= nxt_rseq_ff;
        end
    end

    // Register read value; data port shows live pins outside the latch path
    function automatic logic [7:0] read_mux(logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            IDX_DATA: v = (mode_ff && !wr_act) ? in_lat_ff : pd_in;
            IDX_PINS: v = {4'h0, pe_in};
            IDX_IRQF: v = irqf_ff;
            IDX_DDIR: v = ddir_ff;
            IDX_STAT: v = {ibf_ff, obf_ff, input_overflow_flag_ff, mode_ff, 1'b1, dir_ff};
            IDX_IRQE: v = irqe_ff;
            IDX_ANLG: v = anlg_ff;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Writes finish in zero waits, reads take one wait state
    always_comb begin
        acc = hsel && htrans[1] && hready;
        wcmt = dph_ff && dwr_ff;
        rcap = dph_ff && !dwr_ff && !rwait_ff;
        hreadyout = ce && (!dph_ff || dwr_ff || rwait_ff);
        hresp = 1'b0;
        hrdata = hrdata_ff;
        rd_val = read_mux(didx_ff);
        nxt_dph_ff = dph_ff;
        nxt_dwr_ff = dwr_ff;
        nxt_didx_ff = didx_ff;
        nxt_rwait_ff = rwait_ff;
        nxt_hrdata_ff = hrdata_ff;
        if (hready) begin
            nxt_dph_ff = acc;
            nxt_rwait_ff = 1'b0;
            if (acc) begin
                nxt_dwr_ff = hwrite;
                nxt_didx_ff = haddr[IDX_MSB:IDX_LSB];
            end
        end else if (rcap) begin
            nxt_rwait_ff = 1'b1;
            nxt_hrdata_ff = {24'h0, rd_val};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_ff <= 1'b0;
            dwr_ff <= 1'b0;
            didx_ff <= 8'h00;
            rwait_ff <= 1'b0;
            hrdata_ff <= 32'h0;
        end else if (ce) begin
            dph_ff <= nxt_dph_ff;
            dwr_ff <= nxt_dwr_ff;
            didx_ff <= nxt_didx_ff;
            rwait_ff <= nxt_rwait_ff;
            hrdata_ff <= nxt_hrdata_ff;
        end
    end

    // Latches, flags and the plain registers
    always_comb begin
        wbyte = hwdata[7:0];
        data_rd = rcap && (didx_ff == IDX_DATA);
        data_wr = wcmt && (didx_ff == IDX_DATA);
        nxt_in_lat_ff = in_lat_ff;
        nxt_out_lat_ff = out_lat_ff;
        nxt_pe_lat_ff = pe_lat_ff;
        nxt_ddir_ff = ddir_ff;
        nxt_irqf_ff = irqf_ff;
        nxt_irqe_ff = irqe_ff;
        nxt_anlg_ff = anlg_ff;
        nxt_dir_ff = dir_ff;
        nxt_mode_ff = mode_ff;
        nxt_ibf_ff = ibf_ff;
        nxt_obf_ff = obf_ff;
        nxt_input_overflow_flag_ff = input_overflow_flag_ff;
        nxt_ovf_rd_ff = ovf_rd_ff;
        if (wcmt) begin
            unique case (didx_ff)
                IDX_PINS: nxt_pe_lat_ff = wbyte[2:0];
                IDX_IRQF: nxt_irqf_ff = wbyte;
                IDX_DDIR: nxt_ddir_ff = wbyte;
                IDX_IRQE: nxt_irqe_ff = wbyte;
                IDX_ANLG: nxt_anlg_ff = wbyte;
                IDX_STAT: begin
                    nxt_mode_ff = wbyte[B_MODE];
                    nxt_dir_ff = wbyte[2:0];
                    // Overflow only drops once the byte has also been read
                    if (!wbyte[B_INPUT_OVERFLOW_FLAG] && ovf_rd_ff) begin
                        nxt_input_overflow_flag_ff = 1'b0;
                        nxt_ovf_rd_ff = 1'b0;
                    end
                end
                default: nxt_out_lat_ff = out_lat_ff;
            endcase
        end
        // Same latch serves normal output and external reads
        if (data_wr) begin
            nxt_out_lat_ff = wbyte;
            nxt_obf_ff = 1'b1;
        end
        if (wr_act) begin
            nxt_in_lat_ff = pd2_ff;
        end
        if (data_rd && mode_ff) begin
            nxt_ibf_ff = 1'b0;
            nxt_ovf_rd_ff = 1'b1;
        end
        if (w_fire) begin
            nxt_ibf_ff = 1'b1;
            if (ibf_ff) begin
                nxt_input_overflow_flag_ff = 1'b1;
                nxt_ovf_rd_ff = data_rd;
            end
        end
        if (w_fire || r_fire) begin
            nxt_irqf_ff[B_IRQ] = 1'b1;
        end
        if (rd_act) begin
            nxt_obf_ff = 1'b0;
        end
        if (!mode_ff) begin
            nxt_ibf_ff = 1'b0;
            nxt_obf_ff = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_lat_ff <= LAT_RST;
            out_lat_ff <= LAT_RST;
            pe_lat_ff <= 3'h0;
            ddir_ff <= DDIR_RST;
            irqf_ff <= IRQF_RST;
            irqe_ff <= IRQE_RST;
            anlg_ff <= ANLG_RST;
            dir_ff <= STAT_RST[2:0];
            mode_ff <= STAT_RST[B_MODE];
            ibf_ff <= STAT_RST[B_IBF];
            obf_ff <= STAT_RST[B_OBF];
            input_overflow_flag_ff <= STAT_RST[B_INPUT_OVERFLOW_FLAG];
            ovf_rd_ff <= 1'b0;
        end else if (ce) begin
            in_lat_ff <= nxt_in_lat_ff;
            out_lat_ff <= nxt_out_lat_ff;
            pe_lat_ff <= nxt_pe_lat_ff;
            ddir_ff <= nxt_ddir_ff;
            irqf_ff <= nxt_irqf_ff;
            irqe_ff <= nxt_irqe_ff;
            anlg_ff <= nxt_anlg_ff;
            dir_ff <= nxt_dir_ff;
            mode_ff <= nxt_mode_ff;
            ibf_ff <= nxt_ibf_ff;
            obf_ff <= nxt_obf_ff;
            input_overflow_flag_ff <= nxt_input_overflow_flag_ff;
            ovf_rd_ff <= nxt_ovf_rd_ff;
        end
    end

    // Drive lags the strobes by the two synchroniser stages
    always_comb begin
        pd_out = out_lat_ff;
        pd_oe = mode_ff ? {8{rd_act}} : ~ddir_ff;
        pe_out = pe_lat_ff;
        pe_oe = mode_ff ? 3'h0 : ~dir_ff;
        slave_port_irq = irqf_ff[B_IRQ] && irqe_ff[B_IRQ];
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn || !ce);

    sequence s_wr_close;
        wr_act ##1 (!wr_act && mode_ff);
    endsequence

    sequence s_rd_close;
        rd_act ##1 (!rd_act && mode_ff);
    endsequence

    a_write_flags: assert property (s_wr_close |-> ##[1:8] (ibf_ff && irqf_ff[B_IRQ]))
        else $error("write end did not raise full and irq flags");
    a_flag_phase: assert property ($rose(ibf_ff) |-> $past(q_ff) == PH_Q4)
        else $error("input full rose off phase four");
    a_read_irq: assert property (s_rd_close |-> ##[1:8] irqf_ff[B_IRQ])
        else $error("read end did not raise irq flag");
    a_read_drive: assert property (rd_act |-> pd_oe == 8'hff ##1 !obf_ff)
        else $error("external read not driven or output full kept");
    a_idle_float: assert property (mode_ff && !rd_act |-> pd_oe == 8'h00)
        else $error("data pins driven outside a read");
    a_mode_off: assert property (!mode_ff |=> !ibf_ff && !obf_ff)
        else $error("full flags not held clear with mode off");
    a_ovf_set: assert property (w_fire && ibf_ff |=> input_overflow_flag_ff && ibf_ff)
        else $error("overflow not flagged on write while full");
    a_ovf_hold: assert property (input_overflow_flag_ff && !(wcmt && didx_ff == IDX_STAT) |=> input_overflow_flag_ff)
        else $error("overflow cleared without status write");
    a_ibf_clear: assert property (data_rd && mode_ff && !w_fire |=> !ibf_ff)
        else $error("data read did not clear input full");
    a_ro_bit: assert property (rcap && didx_ff == IDX_STAT |=> hrdata_ff[B_RO])
        else $error("input only direction bit read as zero");
    a_irq_gate: assert property (slave_port_irq |-> irqe_ff[B_IRQ] && irqf_ff[B_IRQ])
        else $error("interrupt raised while disabled");
    a_obf_stay: assert property (!obf_ff && !data_wr |=> !obf_ff)
        else $error("output full rose without firmware write");
endmodule

// ---- common/hsp_pkg.sv ----
// Constants, types and helpers shared by the host slave port
// What this block does
// - Mode bit makes data port a slave
// - Port E pins 0-2 are read, write, select
// - Separate input and output latches, one address
// - Slave mode ignores data port direction register
// - Write window shows live pins to firmware
// - Write end latches data, flags at phase four
// - Data read clears input full flag
// - Write while full sets overflow, overwrites byte
// - Overflow clears after data read, zero write
// - External read drives latch, clears output full
// - Write during read drives new value, flag clear
// - Read end tri-states, flag at phase four
// - Output full stays low until firmware write
// - Mode off holds full flags clear
// - Irq flag cleared by write, gated by enable
// - Pin three direction bit reads as one
// - Direction and status register resets to 0x0f
package hsp_pkg;
    localparam logic [7:0] IDX_DATA = 8'h08;
    localparam logic [7:0] IDX_PINS = 8'h09;
    localparam logic [7:0] IDX_IRQF = 8'h0c;
    localparam logic [7:0] IDX_DDIR = 8'h88;
    localparam logic [7:0] IDX_STAT = 8'h89;
    localparam logic [7:0] IDX_IRQE = 8'h8c;
    localparam logic [7:0] IDX_ANLG = 8'h9f;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    localparam int B_IBF = 7;
    localparam int B_OBF = 6;
    localparam int B_INPUT_OVERFLOW_FLAG = 5;
    localparam int B_MODE = 4;
    localparam int B_RO = 3;
    localparam int B_IRQ = 7;
    localparam logic [7:0] STAT_RST = 8'h0f;
    localparam logic [7:0] IRQF_RST = 8'h00;
    localparam logic [7:0] IRQE_RST = 8'h00;
    localparam logic [7:0] ANLG_RST = 8'h00;
    localparam logic [7:0] DDIR_RST = 8'hff;
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q4 = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WQ2 = 3'h2,
        ST_WQ4 = 3'h4
    } hsp_seq_e;

    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
    } hsp_strb_s;

    // Wait for the next phase two, then fire on the following phase four
    function automatic hsp_seq_e seq_next(hsp_seq_e s, logic start, logic [1:0] q);
        hsp_seq_e r;
        r = s;
        unique case (s)
            ST_IDLE: r = start ? ST_WQ2 : ST_IDLE;
            ST_WQ2: r = (q == PH_Q2) ? ST_WQ4 : ST_WQ2;
            ST_WQ4: r = (q == PH_Q4) ? (start ? ST_WQ2 : ST_IDLE) : ST_WQ4;
            default: r = ST_IDLE;
        endcase
        return r;
    endfunction

    function automatic logic seq_fire(hsp_seq_e s, logic [1:0] q);
        return (s == ST_WQ4) && (q == PH_Q4);
    endfunction
endpackage

// ---- verification/hsp_host_model.sv ----
// Behavioural model of the external processor on the strobe-driven data port
`timescale 1ns/1ns
module hsp_host_model
    import hsp_pkg::*;
(
    input wire logic hclk,
    input wire logic [7:0] pd_out,
    input wire logic [7:0] pd_oe,
    output logic [3:0] pe_in,
    output logic [7:0] pd_in
);
    hsp_strb_s strb = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
    logic [7:0] drv = 8'h00;
    logic drive = 1'b0;

    assign pe_in = {1'b1, strb.cs_n, strb.wr_n, strb.rd_n};

    // Released lines show the inverse of the last byte, never a stale copy
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pd_in[i] = pd_oe[i] ? pd_out[i] : (drive ? drv[i] : ~drv[i]);
        end
    end

    task automatic ext_write(input logic [7:0] d, input int hold);
        @(posedge hclk);
        drv <= d;
        drive <= 1'b1;
        strb.cs_n <= 1'b0;
        strb.wr_n <= 1'b0;
        repeat (hold) @(posedge hclk);
        strb <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
        // Data outlives the release, as capture happens late
        repeat (3) @(posedge hclk);
        drive <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    task automatic ext_read(output logic [7:0] d, input int hold);
        @(posedge hclk);
        strb.cs_n <= 1'b0;
        strb.rd_n <= 1'b0;
        repeat (hold) @(posedge hclk);
        @(negedge hclk);
        d = pd_in;
        @(posedge hclk);
        strb <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1};
        repeat (4) @(posedge hclk);
    endtask
endmodule

// ---- verification/hsp_top_tb.sv ----
// Self-checking bench for the host slave port
`timescale 1ns/1ns
module hsp_top_tb
    import hsp_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, slave_port_irq, rdy_s;
    logic [31:0] hrdata, rd_s;
    logic [7:0] pd_in, pd_out, pd_oe, d1, d2, got;
    logic [3:0] pe_in;
    logic [2:0] pe_oe;
    int err_count = 0;
    int checked = 0;
    integer seed;

    always #5 hclk = ~hclk;
    // Sampled mid-cycle so the edge that follows sees settled values
    always @(negedge hclk) begin
        rdy_s = hreadyout;
        rd_s = hrdata;
    end

    hsp_top hsp_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe), .pe_in(pe_in), .pe_out(),
        .pe_oe(pe_oe), .slave_port_irq(slave_port_irq));

    hsp_host_model hsp_host_model_i (.hclk(hclk), .pd_out(pd_out), .pd_oe(pd_oe),
        .pe_in(pe_in), .pd_in(pd_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected status byte built from the field positions
    function automatic logic [7:0] stat_exp(input logic input_full_flag, input logic output_full_flag,
        input logic input_overflow_flag, input logic mode);
        logic [7:0] v;
        v = STAT_RST;
        v[B_IBF] = input_full_flag;
        v[B_OBF] = output_full_flag;
        v[B_INPUT_OVERFLOW_FLAG] = input_overflow_flag;
        v[B_MODE] = mode;
        return v;
    endfunction

    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        do @(posedge hclk); while (rdy_s !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (rdy_s !== 1'b1);
    endtask

    task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
        bus(1'b1, idx, {24'h0, v});
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rd_s, {24'h0, exp});
    endtask

    task automatic pins_chk(input logic [7:0] exp);
        @(negedge hclk);
        check({24'h0, pd_oe}, {24'h0, exp});
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        err_count++;
        give_verdict();
    end

    initial begin
        seed = 32'hae4eeec0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(IDX_STAT, 8'h0f);
        rchk(IDX_IRQF, 8'h00);
        rchk(IDX_IRQE, 8'h00);
        rchk(8'h40, 8'h00);
        wreg(IDX_ANLG, 8'h0f);
        wreg(IDX_STAT, 8'h17);
        rchk(IDX_STAT, 8'h1f);
        wreg(IDX_DDIR, 8'h00);
        pins_chk(8'h00);
        check({29'h0, pe_oe}, 32'h0);
        $display("test reset and setup done");
        for (int k = 0; k < 4; k++) begin
            d1 = 8'($random(seed));
            hsp_host_model_i.ext_write(d1, 3 + k);
            repeat (8) @(posedge hclk);
            rchk(IDX_STAT, stat_exp(1'b1, 1'b0, 1'b0, 1'b1));
            rchk(IDX_IRQF, 8'h80);
            rchk(IDX_DATA, d1);
            rchk(IDX_STAT, 8'h1f);
            wreg(IDX_IRQF, 8'h00);
            rchk(IDX_IRQF, 8'h00);
        end
        d1 = 8'($random(seed));
        fork
            hsp_host_model_i.ext_write(d1, 16);
            begin
                repeat (8) @(posedge hclk);
                rchk(IDX_DATA, d1);
            end
        join
        rchk(IDX_DATA, d1);
        $display("test external write done");
        d2 = 8'($random(seed));
        hsp_host_model_i.ext_write(~d2, 4);
        hsp_host_model_i.ext_write(d2, 4);
        repeat (8) @(posedge hclk);
        rchk(IDX_STAT, 8'hbf);
        wreg(IDX_STAT, 8'h17);
        rchk(IDX_STAT, 8'hbf);
        rchk(IDX_DATA, d2);
        wreg(IDX_STAT, 8'h17);
        rchk(IDX_STAT, 8'h1f);
        $display("test overflow done");
        wreg(IDX_IRQE, 8'h80);
        @(negedge hclk);
        check({31'h0, slave_port_irq}, 32'h1);
        wreg(IDX_IRQE, 8'h00);
        @(negedge hclk);
        check({31'h0, slave_port_irq}, 32'h0);
        wreg(IDX_IRQF, 8'h00);
        wreg(IDX_IRQE, 8'h80);
        @(negedge hclk);
        check({31'h0, slave_port_irq}, 32'h0);
        $display("test interrupt done");
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        wreg(IDX_DATA, d1);
        rchk(IDX_STAT, 8'h5f);
        fork
            hsp_host_model_i.ext_read(got, 18);
            begin
                repeat (5) @(posedge hclk);
                pins_chk(8'hff);
                @(posedge hclk);
                rchk(IDX_STAT, 8'h1f);
                wreg(IDX_DATA, d2);
            end
        join
        check({24'h0, got}, {24'h0, d2});
        repeat (6) @(posedge hclk);
        pins_chk(8'h00);
        rchk(IDX_STAT, 8'h1f);
        rchk(IDX_IRQF, 8'h80);
        wreg(IDX_DATA, d1);
        rchk(IDX_STAT, 8'h5f);
        $display("test external read done");
        hsp_host_model_i.ext_write(d1, 4);
        hsp_host_model_i.ext_write(d2, 4);
        repeat (8) @(posedge hclk);
        rchk(IDX_STAT, stat_exp(1'b1, 1'b1, 1'b1, 1'b1));
        wreg(IDX_STAT, 8'h07);
        rchk(IDX_STAT, 8'h2f);
        pins_chk(8'hff);
        wreg(IDX_IRQF, 8'h00);
        hsp_host_model_i.ext_write(d1, 4);
        repeat (8) @(posedge hclk);
        rchk(IDX_STAT, 8'h2f);
        rchk(IDX_IRQF, 8'h00);
        check({31'h0, hresp}, 32'h0);
        // Clock enable low must stall the bus
        ce <= 1'b0;
        @(negedge hclk);
        check({31'h0, hreadyout}, 32'h0);
        @(posedge hclk);
        ce <= 1'b1;
        rchk(IDX_STAT, stat_exp(1'b0, 1'b0, 1'b1, 1'b0));
        $display("test mode off done");
        give_verdict();
    end
endmodule
